// >>> hdl/chan_cmp_if.sv
// Carrier for the per-sample comparison results of one analog channel.
// Assumes producer and consumer share one clock.
`timescale 1ns/10ps
interface chan_cmp_if;
  logic tick;
  logic above;
  logic rise;
  logic fall;
  modport src (output tick, output above, output rise, output fall);
  modport dst (input tick, input above, input rise, input fall);
endinterface : chan_cmp_if

// >>> hdl/chan_compare.sv
// Level comparator and crossing detector for one analog channel.
// Assumes samples arrive in the clock domain with a sample strobe.
`timescale 1ns/10ps
module chan_compare
  import gate_trigger_pkg::*;
#(
  parameter int SAMPLE_W = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_sample_en,
  input wire logic signed [SAMPLE_W-1:0] i_sample,
  input wire logic signed [SAMPLE_W-1:0] i_level,
  chan_cmp_if.src cmp
);

  typedef struct packed {
    logic seen;
    logic tick;
    logic above;
    logic rise;
    logic fall;
  } cmp_state_s;

  cmp_state_s state_q;
  cmp_state_s state_d;
  logic now_above;

  always_comb begin
    now_above = (i_sample >= i_level);
    state_d = state_q;
    state_d.tick = 1'b0;
    state_d.rise = 1'b0;
    state_d.fall = 1'b0;
    if (!i_run) begin
      state_d.seen = 1'b0;
    end else if (i_sample_en) begin
      state_d.tick = 1'b1;
      state_d.above = now_above;
      state_d.seen = 1'b1;
      // Without a sample taken since start no crossing can be claimed.
      state_d.rise = state_q.seen && !state_q.above && now_above;
      state_d.fall = state_q.seen && state_q.above && !now_above;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign cmp.tick = state_q.tick;
  assign cmp.above = state_q.above;
  assign cmp.rise = state_q.rise;
  assign cmp.fall = state_q.fall;

endmodule : chan_compare

// >>> hdl/gate_trigger_pkg.sv
// Constants shared by the gated sampling trigger engine and its helpers.
// Assumes every user sits on the single sample-domain clock.
package gate_trigger_pkg;

  // ---------------------------------------------------------------
  // Register numbers, taken as plain addresses on the register port
  // ---------------------------------------------------------------
  localparam int REG_ADDR_W = 16;
  localparam logic [REG_ADDR_W-1:0] ADDR_SOURCE_OR_MASK = 16'h9DDA;
  localparam logic [REG_ADDR_W-1:0] ADDR_CHANNEL_OR_MASK = 16'h9E0C;
  localparam logic [REG_ADDR_W-1:0] ADDR_EXT_MODE = 16'h9E3E;
  localparam logic [REG_ADDR_W-1:0] ADDR_CH0_MODE = 16'h9EA2;
  localparam logic [REG_ADDR_W-1:0] ADDR_CH0_LEVEL = 16'hA4D8;
  localparam logic [REG_ADDR_W-1:0] ADDR_EXT_PULSEWIDTH = 16'hACB2;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Mask bits
  // ---------------------------------------------------------------
  localparam int EXTERNAL_INPUT_ENABLE_POS = 1;
  localparam int EXTRA_INPUT_ZERO_ENABLE_POS = 8;
  localparam int EXTRA_INPUT_ONE_ENABLE_POS = 9;
  localparam int CHANNEL_ZERO_ENABLE_POS = 0;

  // ---------------------------------------------------------------
  // Mode encodings
  // ---------------------------------------------------------------
  localparam logic [31:0] EXT_MODE_NEG_DOUBLE_EDGE = 32'h0800_0002;
  localparam logic [31:0] EXT_MODE_LONG_HIGH = 32'h0400_0001;
  localparam logic [31:0] EXT_MODE_LONG_LOW = 32'h0400_0002;
  localparam logic [31:0] CH_MODE_RISING_EDGE = 32'h0000_0001;
  localparam logic [31:0] CH_MODE_HIGH_LEVEL = 32'h0000_0008;

  // ---------------------------------------------------------------
  // Pulsewidth limits, in sample periods
  // ---------------------------------------------------------------
  localparam int PW_W = 16;
  localparam logic [PW_W-1:0] PW_MIN = 16'h0002;
  localparam logic [PW_W-1:0] PW_MAX = 16'hFFFF;
  localparam logic [PW_W-1:0] PW_FIRST = 16'h0001;

  typedef enum logic [1:0] {
    EXT_WAIT = 2'b00,
    EXT_MEASURE = 2'b01,
    EXT_OPEN = 2'b10
  } ext_state_e;

endpackage : gate_trigger_pkg

// >>> hdl/gated_sampling_trigger.sv
// Gated sampling trigger engine: register set, external TTL gate modes
// and channel 0 gate modes, merged into one acquisition gate.
// Assumes the register port, run level and samples share i_clock; the
// TTL inputs are asynchronous pins.
//
// Contract
// - Double-edge: first falling edge opens gate.
// - Double-edge: second falling edge closes gate.
// - Low level at start opens nothing.
// - Mode 08000002h means negative double-edge gate.
// - External input needs mask bit 2h.
// - Mask bits 100h, 200h for fitted extra inputs.
// - Long-HIGH mode 4000001h needs long high.
// - First qualifying pulse after start opens gate.
// - Long-HIGH: next falling edge closes gate.
// - Long-LOW mode 4000002h needs long low.
// - Long-LOW: next rising edge closes gate.
// - Pulsewidth threshold 2 to 65535 samples.
// - Channel 0 needs channel mask bit 1h.
// - Every channel sample compared with level.
// - Rising mode 1h: upward crossing opens.
// - Rising mode: downward crossing closes gate.
// - Already-high signal at start opens nothing.
// - HIGH mode 8h: open while at level.
// - HIGH mode: sample below level closes.
// - HIGH mode: high at start opens immediately.
`timescale 1ns/10ps
module gated_sampling_trigger
  import gate_trigger_pkg::*;
#(
  parameter int SAMPLE_W = 8,
  parameter bit EXTRA_IO_FITTED = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  input wire logic i_run,
  input wire logic i_ext_ttl,
  input wire logic i_extra_ttl_zero,
  input wire logic i_extra_ttl_one,
  input wire logic i_sample_en,
  input wire logic signed [SAMPLE_W-1:0] i_sample,
  output logic o_gate
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Registers, sync stages and gate state in one record.
  typedef struct packed {
    logic [31:0] source_mask;
    logic [31:0] channel_mask;
    logic [31:0] ext_mode;
    logic [31:0] ch_mode;
    logic [31:0] ch_level;
    logic [31:0] pulsewidth;
    logic [31:0] rdata;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic ttl_prev;
    logic ttl_seen;
    ext_state_e ext_state;
    logic ch_gate;
    logic gate;
  } top_state_s;

  top_state_s state_q;
  top_state_s state_d;

  // Channel 0 results travel as one bundle.
  chan_cmp_if cmp ();

  // Handshake with the pulsewidth counter.
  logic pw_restart;
  logic pw_count;
  logic pw_reached;
  logic [PW_W-1:0] pw_threshold;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic mask_bit(input logic [31:0] mask, input int pos);
    mask_bit = mask[pos];
  endfunction : mask_bit

  function automatic logic is_pw_mode(input logic [31:0] mode);
    is_pw_mode = (mode == EXT_MODE_LONG_HIGH) || (mode == EXT_MODE_LONG_LOW);
  endfunction : is_pw_mode

  // Extra inputs count only where their hardware is fitted.
  function automatic logic source_enabled(input logic [31:0] mask);
    source_enabled = mask_bit(mask, EXTERNAL_INPUT_ENABLE_POS)
      || (EXTRA_IO_FITTED && mask_bit(mask, EXTRA_INPUT_ZERO_ENABLE_POS))
      || (EXTRA_IO_FITTED && mask_bit(mask, EXTRA_INPUT_ONE_ENABLE_POS));
  endfunction : source_enabled

  // ---------------------------------------------------------------
  // Channel comparator
  // ---------------------------------------------------------------
  // Only the low level bits meet the signed compare.
  chan_compare #(
    .SAMPLE_W(SAMPLE_W)
  ) u_chan_compare (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_run(i_run),
    .i_sample_en(i_sample_en),
    .i_sample(i_sample),
    .i_level(state_q.ch_level[SAMPLE_W-1:0]),
    .cmp(cmp.src)
  );

  // ---------------------------------------------------------------
  // Pulsewidth counter
  // ---------------------------------------------------------------
  // Values below the legal floor are lifted to it rather than refused,
  // so a careless host still gets a defined filter.
  assign pw_threshold = (state_q.pulsewidth[PW_W-1:0] < PW_MIN) ?
                        PW_MIN : state_q.pulsewidth[PW_W-1:0];

  pw_counter u_pw_counter (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_restart(pw_restart),
    .i_count(pw_count),
    .i_threshold(pw_threshold),
    .o_reached(pw_reached)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Next-state terms, rebuilt every cycle.
  logic [2:0] ttl_sync;
  logic ttl_line;
  logic ttl_active;
  logic prev_active;
  logic ext_edge;
  logic ext_rise;
  logic ext_fall;
  logic ext_take;
  logic ext_gate;
  logic ch_enable;
  logic mode_write;

  always_comb begin
    state_d = state_q;
    pw_restart = 1'b0;
    pw_count = 1'b0;

    // ----------------
    // Pin synchronisers
    // ----------------
    // Two flip-flops on every pin before anything looks at it.
    // Unfitted pins are synced too; the path stays uniform.
    state_d.sync_a = {i_extra_ttl_one, i_extra_ttl_zero, i_ext_ttl};
    state_d.sync_b = state_q.sync_a;
    ttl_sync = state_q.sync_b;

    // Disabled or unfitted inputs do not take part in the OR.
    ttl_line = (ttl_sync[0] && mask_bit(state_q.source_mask, EXTERNAL_INPUT_ENABLE_POS))
      || (EXTRA_IO_FITTED && ttl_sync[1]
          && mask_bit(state_q.source_mask, EXTRA_INPUT_ZERO_ENABLE_POS))
      || (EXTRA_IO_FITTED && ttl_sync[2]
          && mask_bit(state_q.source_mask, EXTRA_INPUT_ONE_ENABLE_POS));

    // ----------------
    // Register port
    // ----------------
    // Register writes.
    // A mode write restarts the external machine.
    mode_write = 1'b0;
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_SOURCE_OR_MASK: state_d.source_mask = i_reg_wdata;
        ADDR_CHANNEL_OR_MASK: state_d.channel_mask = i_reg_wdata;
        ADDR_EXT_MODE: begin
          state_d.ext_mode = i_reg_wdata;
          mode_write = 1'b1;
        end
        ADDR_CH0_MODE: state_d.ch_mode = i_reg_wdata;
        ADDR_CH0_LEVEL: state_d.ch_level = i_reg_wdata;
        ADDR_EXT_PULSEWIDTH: state_d.pulsewidth = i_reg_wdata;
        default: ;
      endcase
    end

    // A read beside a write returns the old value.
    // Register reads, answered one cycle later; unmapped reads give zero.
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_SOURCE_OR_MASK: state_d.rdata = state_q.source_mask;
        ADDR_CHANNEL_OR_MASK: state_d.rdata = state_q.channel_mask;
        ADDR_EXT_MODE: state_d.rdata = state_q.ext_mode;
        ADDR_CH0_MODE: state_d.rdata = state_q.ch_mode;
        ADDR_CH0_LEVEL: state_d.rdata = state_q.ch_level;
        ADDR_EXT_PULSEWIDTH: state_d.rdata = state_q.pulsewidth;
        default: state_d.rdata = REG_RESET;
      endcase
    end

    // ----------------
    // External edges
    // ----------------
    // External edges, against the previous sample taken since start.
    // Long-LOW inverts the sense; one detector serves both.
    ttl_active = (state_q.ext_mode == EXT_MODE_LONG_HIGH) ? ttl_line : !ttl_line;
    prev_active = (state_q.ext_mode == EXT_MODE_LONG_HIGH) ?
                  state_q.ttl_prev : !state_q.ttl_prev;
    ext_take = i_run && i_sample_en;
    ext_edge = ext_take && state_q.ttl_seen && ttl_active && !prev_active;
    ext_rise = ext_take && state_q.ttl_seen && ttl_line && !state_q.ttl_prev;
    ext_fall = ext_take && state_q.ttl_seen && !ttl_line && state_q.ttl_prev;

    // A stop forgets the last sample, so no edge spans two runs.
    if (!i_run) begin
      state_d.ttl_seen = 1'b0;
    end else if (i_sample_en) begin
      state_d.ttl_prev = ttl_line;
      state_d.ttl_seen = 1'b1;
    end

    // ----------------
    // External gate machine
    // ----------------
    // A new mode inherits no half-measured pulse or open gate.
    if (!i_run || mode_write) begin
      state_d.ext_state = EXT_WAIT;
    end else begin
      case (state_q.ext_state)
        EXT_WAIT: begin
          // Double edge opens on a fall; pulse modes measure first.
          if (state_q.ext_mode == EXT_MODE_NEG_DOUBLE_EDGE) begin
            if (ext_fall) begin
              state_d.ext_state = EXT_OPEN;
            end
          end else if (is_pw_mode(state_q.ext_mode) && ext_edge) begin
            pw_restart = 1'b1;
            state_d.ext_state = EXT_MEASURE;
          end
        end
        EXT_MEASURE: begin
          if (!is_pw_mode(state_q.ext_mode)) begin
            state_d.ext_state = EXT_WAIT;
          end else if (ext_take) begin
            if (!ttl_active) begin
              // Too short: back to waiting for the next qualifying edge.
              state_d.ext_state = EXT_WAIT;
            end else if (pw_reached) begin
              // The edge sample counted as one, so only a pulse
              // longer than the threshold gets here.
              state_d.ext_state = EXT_OPEN;
            end else begin
              pw_count = 1'b1;
            end
          end
        end
        EXT_OPEN: begin
          case (state_q.ext_mode)
            EXT_MODE_NEG_DOUBLE_EDGE: begin
              if (ext_fall) begin
                state_d.ext_state = EXT_WAIT;
              end
            end
            EXT_MODE_LONG_HIGH: begin
              if (ext_fall) begin
                state_d.ext_state = EXT_WAIT;
              end
            end
            EXT_MODE_LONG_LOW: begin
              if (ext_rise) begin
                state_d.ext_state = EXT_WAIT;
              end
            end
            default: state_d.ext_state = EXT_WAIT;
          endcase
        end
        default: state_d.ext_state = EXT_WAIT;
      endcase
    end

    // The machine runs on the OR of enabled inputs.
    ext_gate = (state_q.ext_state == EXT_OPEN)
               && source_enabled(state_q.source_mask);

    // ----------------
    // Channel 0 gate
    // ----------------
    // An unknown mode keeps the gate shut.
    ch_enable = mask_bit(state_q.channel_mask, CHANNEL_ZERO_ENABLE_POS);
    if (!i_run || !ch_enable) begin
      state_d.ch_gate = 1'b0;
    end else begin
      // Edge mode holds its gate between crossings.
      case (state_q.ch_mode)
        CH_MODE_RISING_EDGE: begin
          if (cmp.rise) begin
            state_d.ch_gate = 1'b1;
          end else if (cmp.fall) begin
            state_d.ch_gate = 1'b0;
          end
        end
        CH_MODE_HIGH_LEVEL: begin
          if (cmp.tick) begin
            // The first sample after start already counts as a level.
            state_d.ch_gate = cmp.above;
          end
        end
        default: state_d.ch_gate = 1'b0;
      endcase
    end

    // ----------------
    // Merged gate
    // ----------------
    // A stop closes the gate one cycle later.
    state_d.gate = i_run && (ext_gate || state_q.ch_gate);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Reset clears the whole set: registers read zero,
  // and the gate starts closed.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= '0;
      state_q.ext_state <= EXT_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // Both outputs come straight from flip-flops.
  assign o_reg_rdata = state_q.rdata;
  assign o_gate = state_q.gate;

endmodule : gated_sampling_trigger

// >>> hdl/pw_counter.sv
// Pulsewidth counter counting sample periods of an active phase.
// Assumes restart and count arrive as same-clock qualified strobes.
`timescale 1ns/10ps
module pw_counter
  import gate_trigger_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire logic i_count,
  input wire logic [PW_W-1:0] i_threshold,
  output logic o_reached
);

  typedef struct packed {
    logic [PW_W-1:0] cnt;
  } pw_state_s;

  pw_state_s state_q;
  pw_state_s state_d;

  always_comb begin
    state_d = state_q;
    if (i_restart) begin
      state_d.cnt = PW_FIRST;
    end else if (i_count && state_q.cnt != PW_MAX) begin
      state_d.cnt = state_q.cnt + PW_FIRST;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_reached = (state_q.cnt >= i_threshold);

endmodule : pw_counter

// >>> test/gate_trigger_monitor.sv
// Port checker for the gated sampling trigger engine.
// Assumes it is bound onto every instance of the engine.
`timescale 1ns/10ps
module gate_trigger_monitor
  import gate_trigger_pkg::*;
#(
  parameter int SAMPLE_W = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic [REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_run,
  input wire logic i_ext_ttl,
  input wire logic i_sample_en,
  input wire logic signed [SAMPLE_W-1:0] i_sample,
  input wire logic o_gate
);
  // Shadow copies of the registers; checks are blanked for eight cycles after a
  // write or a stop, because the pipeline may still carry the old setup.
  logic [31:0] src_q;
  logic [31:0] chm_q;
  logic [31:0] ext_q;
  logic [31:0] mode_q;
  logic signed [SAMPLE_W-1:0] lvl_q;
  logic signed [SAMPLE_W-1:0] prev_q;
  logic [3:0] settle_q;
  logic ext_only;
  logic ch_only;
  always_ff @(posedge i_clock) begin
    if (i_sample_en) begin
      prev_q <= i_sample;
    end
    if (!i_rst_n || i_reg_wr || !i_run) begin
      settle_q <= 4'h0;
    end else if (settle_q != 4'hF) begin
      settle_q <= settle_q + 4'h1;
    end
    if (!i_rst_n) begin
      src_q <= 32'h0;
      chm_q <= 32'h0;
      ext_q <= 32'h0;
      mode_q <= 32'h0;
      lvl_q <= '0;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_SOURCE_OR_MASK: src_q <= i_reg_wdata;
        ADDR_CHANNEL_OR_MASK: chm_q <= i_reg_wdata;
        ADDR_EXT_MODE: ext_q <= i_reg_wdata;
        ADDR_CH0_MODE: mode_q <= i_reg_wdata;
        ADDR_CH0_LEVEL: lvl_q <= i_reg_wdata[SAMPLE_W-1:0];
        default: ;
      endcase
    end
  end
  assign ext_only = settle_q[3] && src_q[EXTERNAL_INPUT_ENABLE_POS] && !chm_q[0];
  assign ch_only = settle_q[3] && chm_q[CHANNEL_ZERO_ENABLE_POS] && !src_q[1];
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  chk_masked_quiet: assert property (
    settle_q[3] && !src_q[1] && !chm_q[0] |-> !o_gate) else $error("gate open while masked");
  chk_neg_fall_toggle: assert property (
    ext_only && ext_q == EXT_MODE_NEG_DOUBLE_EDGE && $fell(i_ext_ttl)
    |-> ##[1:6] ($changed(o_gate) || !settle_q[3])) else $error("falling edge missed");
  chk_neg_rise_hold: assert property (
    ext_only && ext_q == EXT_MODE_NEG_DOUBLE_EDGE && $rose(i_ext_ttl)
    |=> ($stable(o_gate) || !settle_q[3]) [*6]) else $error("rising edge moved gate");
  chk_high_fall_close: assert property (
    ext_only && ext_q == EXT_MODE_LONG_HIGH && $fell(i_ext_ttl) && o_gate
    |-> ##[1:6] (!o_gate || !settle_q[3])) else $error("long high gate not closed");
  chk_low_rise_close: assert property (
    ext_only && ext_q == EXT_MODE_LONG_LOW && $rose(i_ext_ttl) && o_gate
    |-> ##[1:6] (!o_gate || !settle_q[3])) else $error("long low gate not closed");
  chk_cross_up_open: assert property (
    ch_only && mode_q == CH_MODE_RISING_EDGE && i_sample_en && i_sample >= lvl_q
    && prev_q < lvl_q |-> ##[1:4] (o_gate || !settle_q[3])) else $error("crossing missed");
  chk_below_close: assert property (
    ch_only && (mode_q == CH_MODE_RISING_EDGE || mode_q == CH_MODE_HIGH_LEVEL) && i_sample_en
    && i_sample < lvl_q |-> ##[1:4] (!o_gate || !settle_q[3])) else $error("gate kept open");
  chk_level_open: assert property (
    ch_only && mode_q == CH_MODE_HIGH_LEVEL && i_sample_en && i_sample >= lvl_q
    |-> ##[1:4] (o_gate || !settle_q[3])) else $error("high level gate not open");
endmodule : gate_trigger_monitor

bind gated_sampling_trigger gate_trigger_monitor #(.SAMPLE_W(SAMPLE_W)) u_gate_trigger_monitor (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_run(i_run), .i_ext_ttl(i_ext_ttl),
  .i_sample_en(i_sample_en), .i_sample(i_sample), .o_gate(o_gate));

// >>> test/gated_sampling_trigger_tb_top.sv
// Self-checking bench for the gated sampling trigger engine.
// Assumes the far-side model drives the pins and the checker is bound in.
`timescale 1ns/10ps
module gated_sampling_trigger_tb_top
  import gate_trigger_pkg::*;
;
  logic clock;
  logic rst_n;
  logic reg_wr;
  logic reg_rd;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] rd;
  logic run;
  logic ext_ttl;
  logic extra_zero;
  logic extra_one;
  logic sample_en;
  logic signed [7:0] sample;
  logic gate;
  logic act;
  int err_total;
  int check_count;
  int gate_hi;
  int mark;
  logic [REG_ADDR_W-1:0] addrs [6] = '{ADDR_SOURCE_OR_MASK, ADDR_CHANNEL_OR_MASK,
    ADDR_EXT_MODE, ADDR_CH0_MODE, ADDR_CH0_LEVEL, ADDR_EXT_PULSEWIDTH};
  gated_sampling_trigger u_gated_sampling_trigger (
    .i_clock(clock), .i_rst_n(rst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_run(run),
    .i_ext_ttl(ext_ttl), .i_extra_ttl_zero(extra_zero), .i_extra_ttl_one(extra_one),
    .i_sample_en(sample_en), .i_sample(sample), .o_gate(gate));
  ttl_chan_model u_ttl_chan_model (
    .i_clock(clock), .o_ext_ttl(ext_ttl), .o_extra_ttl_zero(extra_zero),
    .o_extra_ttl_one(extra_one), .o_sample_en(sample_en), .o_sample(sample));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Counting open cycles catches a brief gate that fixed-time samples would miss.
  always @(posedge clock) begin
    if (gate === 1'b1) gate_hi++;
  end
  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t word %h, expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task cmp_gate(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t gate %b, expected %b", $time, got, exp);
    end
  endtask : cmp_gate
  task reg_write(input logic [REG_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [REG_ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask : reg_read
  task start(input logic [31:0] src, input logic [31:0] ext, input logic [31:0] chm,
      input logic [31:0] chmode);
    @(posedge clock);
    run <= 1'b0;
    reg_write(ADDR_SOURCE_OR_MASK, src);
    reg_write(ADDR_EXT_MODE, ext);
    reg_write(ADDR_CHANNEL_OR_MASK, chm);
    reg_write(ADDR_CH0_MODE, chmode);
    @(posedge clock);
    run <= 1'b1;
    repeat (12) @(posedge clock);
  endtask : start
  task test_end(input string name);
    $display("test %s done", name);
  endtask : test_end
  task wrap_up;
    $display("checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    run = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    foreach (addrs[k]) begin
      reg_read(addrs[k], rd);
      cmp_word(rd, REG_RESET);
      reg_write(addrs[k], 32'hA53C_F000 | 32'(k));
      reg_read(addrs[k], rd);
      cmp_word(rd, 32'hA53C_F000 | 32'(k));
    end
    reg_write(16'h0000, 32'hFFFF_FFFF);
    reg_read(16'h0000, rd);
    cmp_word(rd, 32'h0000_0000);
    reg_write(ADDR_SOURCE_OR_MASK, 32'h0000_0300);
    reg_read(ADDR_SOURCE_OR_MASK, rd);
    cmp_word(rd, 32'h0000_0300);
    reg_write(ADDR_EXT_PULSEWIDTH, 32'h0000_FFFF);
    reg_read(ADDR_EXT_PULSEWIDTH, rd);
    cmp_word(rd, 32'h0000_FFFF);
    test_end("registers");
    // A falling edge before the start must be forgotten.
    u_ttl_chan_model.drive_ttl(1'b1, 4);
    u_ttl_chan_model.drive_ttl(1'b0, 4);
    start(32'h2, EXT_MODE_NEG_DOUBLE_EDGE, 32'h0, 32'h0);
    cmp_gate(gate, 1'b0);
    u_ttl_chan_model.drive_ttl(1'b1, 12);
    u_ttl_chan_model.drive_ttl(1'b0, 12);
    cmp_gate(gate, 1'b1);
    u_ttl_chan_model.drive_ttl(1'b1, 12);
    cmp_gate(gate, 1'b1);
    u_ttl_chan_model.drive_ttl(1'b0, 12);
    cmp_gate(gate, 1'b0);
    u_ttl_chan_model.drive_ttl(1'b1, 12);
    u_ttl_chan_model.drive_ttl(1'b0, 12);
    cmp_gate(gate, 1'b1);
    start(32'h100, EXT_MODE_NEG_DOUBLE_EDGE, 32'h0, 32'h0);
    mark = gate_hi;
    u_ttl_chan_model.drive_extra(1'b1);
    u_ttl_chan_model.drive_ttl(1'b1, 12);
    u_ttl_chan_model.drive_extra(1'b0);
    u_ttl_chan_model.drive_ttl(1'b0, 12);
    cmp_gate(gate_hi != mark, 1'b0);
    test_end("double edge");
    for (int m = 0; m < 2; m++) begin
      act = (m == 0);
      reg_write(ADDR_EXT_PULSEWIDTH, 32'h0000_0004);
      u_ttl_chan_model.drive_ttl(!act, 2);
      start(32'h2, act ? EXT_MODE_LONG_HIGH : EXT_MODE_LONG_LOW, 32'h0, 32'h0);
      mark = gate_hi;
      u_ttl_chan_model.drive_ttl(act, 2);
      u_ttl_chan_model.drive_ttl(!act, 12);
      cmp_gate(gate_hi != mark, 1'b0);
      u_ttl_chan_model.drive_ttl(act, 20);
      cmp_gate(gate, 1'b1);
      u_ttl_chan_model.drive_ttl(!act, 12);
      cmp_gate(gate, 1'b0);
    end
    test_end("pulsewidth");
    reg_write(ADDR_CH0_LEVEL, 32'h0000_000A);
    u_ttl_chan_model.drive_sample(8'sd20, 1);
    start(32'h0, 32'h0, 32'h1, CH_MODE_RISING_EDGE);
    cmp_gate(gate, 1'b0);
    u_ttl_chan_model.drive_sample(8'sd5, 8);
    u_ttl_chan_model.drive_sample(8'sd10, 8);
    cmp_gate(gate, 1'b1);
    u_ttl_chan_model.drive_sample(8'sd9, 8);
    cmp_gate(gate, 1'b0);
    start(32'h0, 32'h0, 32'h0, CH_MODE_RISING_EDGE);
    mark = gate_hi;
    u_ttl_chan_model.drive_sample(8'sd5, 8);
    u_ttl_chan_model.drive_sample(8'sd20, 8);
    cmp_gate(gate_hi != mark, 1'b0);
    test_end("channel edge");
    start(32'h0, 32'h0, 32'h1, CH_MODE_HIGH_LEVEL);
    cmp_gate(gate, 1'b1);
    u_ttl_chan_model.drive_sample(8'sd10, 8);
    cmp_gate(gate, 1'b1);
    u_ttl_chan_model.drive_sample(-8'sd4, 8);
    cmp_gate(gate, 1'b0);
    test_end("channel level");
    wrap_up();
  end
endmodule : gated_sampling_trigger_tb_top

// >>> test/ttl_chan_model.sv
// Far-side model: external TTL sources and the digitised channel 0.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/10ps
module ttl_chan_model #(
  parameter int SAMPLE_W = 8
) (
  input wire logic i_clock,
  output logic o_ext_ttl,
  output logic o_extra_ttl_zero,
  output logic o_extra_ttl_one,
  output logic o_sample_en,
  output logic signed [SAMPLE_W-1:0] o_sample
);
  // The channel is digitised on every clock, so the strobe never drops.
  initial begin
    o_ext_ttl = 1'b0;
    o_extra_ttl_zero = 1'b0;
    o_extra_ttl_one = 1'b0;
    o_sample_en = 1'b1;
    o_sample = '0;
  end
  task drive_ttl(input logic lvl, input int hold);
    @(posedge i_clock);
    o_ext_ttl <= lvl;
    repeat (hold) @(posedge i_clock);
  endtask : drive_ttl
  task drive_extra(input logic lvl);
    @(posedge i_clock);
    o_extra_ttl_zero <= lvl;
    o_extra_ttl_one <= lvl;
  endtask : drive_extra
  task drive_sample(input logic signed [SAMPLE_W-1:0] s, input int hold);
    @(posedge i_clock);
    o_sample <= s;
    repeat (hold) @(posedge i_clock);
  endtask : drive_sample
endmodule : ttl_chan_model
